//--- rtl/dfs_pkg.sv
// package for the dynamic fan-start temperature loop
package dfs_pkg;

    // ------------------------------------------------------------
    // register map (word indices; byte address is the index shifted left by 2)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_OP_R1      = 8'h33;
    localparam logic [7:0] IDX_OP_LOC     = 8'h34;
    localparam logic [7:0] IDX_OP_R2      = 8'h35;
    localparam logic [7:0] IDX_CTRL1      = 8'h36;
    localparam logic [7:0] IDX_CTRL2      = 8'h37;
    localparam logic [7:0] IDX_FST_R1     = 8'h40;
    localparam logic [7:0] IDX_FST_LOC    = 8'h41;
    localparam logic [7:0] IDX_FST_R2     = 8'h42;
    localparam logic [7:0] IDX_MODE       = 8'h43;
    localparam logic [7:0] IDX_ACOU       = 8'h44;
    localparam int         ADDR_W         = 10;

    // ------------------------------------------------------------
    // fields of control 1, control 2 and mode
    // ------------------------------------------------------------
    localparam int CTRL1_CY2_HI_BIT  = 0;
    localparam int CTRL1_CAP_LSB     = 2;
    localparam int CTRL1_DYN_LSB     = 5;
    localparam int CTRL2_CY1_LSB     = 0;
    localparam int CTRL2_CYL_LSB     = 3;
    localparam int CTRL2_CY2_LSB     = 6;
    localparam int MODE_OFS64_BIT    = 0;
    localparam int MODE_ACOU_EN_BIT  = 1;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0] OP_RESET       = 8'ha4;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] FST_RESET      = 8'h5a;
    localparam logic [7:0] ACOU_RESET     = 8'h01;
    localparam logic [7:0] FLOOR_TWOS     = 8'h81;  // -127 in twos complement
    localparam logic [7:0] FLOOR_OFS64    = 8'h00;  // -64 in offset-64
    localparam logic [9:0] SLOW_RISE_QTR  = 10'h001; // 0.25 degC in quarters
    localparam logic [9:0] LONG_STEP      = 10'h004; // 1 degC in quarters
    localparam int         BASE_SHORT     = 8;
    localparam int         NCH            = 3;

    // per-channel inputs from the measurement side
    typedef struct packed {
        logic [9:0] temp;    // 8.2 fixed point, degC quarters
        logic [7:0] hyst;
        logic [7:0] low_lim;
        logic [7:0] high_lim;
    } dfs_chan_in_t;

endpackage

//--- rtl/dfs_loop.sv
// dynamic fan-start temperature loop with wishbone register slave
//
// Behaviour
// R01: below operating point minus hysteresis, hold
// R02: short cycle lowers by twice the rise
// R03: rise of 0.25 or less: no cut
// R04: long cycle holds between op-hyst and op
// R05: above operating point, long cycle lowers 1
// R06: below operating point again, value held
// R07: long cycle raise needs four conditions
// R08: never above channel high limit; code only blocks raises past it, a fan start already above the limit is kept
// R09: above low limit, raising stops
// R10: floor -127 twos or -64 offset-64
// R11: temp below fan start suspends adjustment
// R12: remote2 capture on alarm when enabled
// R13: local capture on alarm when enabled
// R14: remote1 capture on alarm when enabled
// R15: capture disabled keeps programmed operating point
// R16: control bits 7:5 enable dynamic channels
// R17: dynamic disabled never touches fan start
// R18: acoustic mode limits duty change per update
// R19: short every n, long every 2n cycles
// R20: 3-bit code, 8 doubling to 1024
// R21: one 8-bit operating point per channel
// R22: alarm active low, synchronised, edge captured
// R23: channels evaluated independently at cycle end
`timescale 1ns/1ns
module dfs_loop #(
    parameter int DUTY_W = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [9:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // monitoring cycle tick and per-channel measurements (0 r1, 1 local, 2 r2)
    input  wire logic                  mon_tick_i,
    input  wire dfs_pkg::dfs_chan_in_t ch_i [3],
    input  wire logic                  thermal_alarm_n_i,
    // duty from the base curve, smoothed duty out
    input  wire logic [DUTY_W-1:0]     duty_target_i,
    output logic      [DUTY_W-1:0]     duty_o,
    output logic      [23:0]           fan_start_temp_o,
    output logic      [2:0]            fan_off_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0][7:0]  op;
        logic [2:0][7:0]  fst;
        logic [2:0][9:0]  prev_temp;
        logic [2:0][10:0] cnt;
        logic [7:0]       ctrl1;
        logic [7:0]       ctrl2;
        logic [7:0]       mode;
        logic [7:0]       acou;
        logic [DUTY_W-1:0] duty;
        logic             alarm_s1;
        logic             alarm_s2;
        logic             alarm_s3;
        logic [31:0]      rdat;
        logic             ack;
    } dfs_state_t;

    dfs_state_t st_r;
    dfs_state_t st_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // cycle code of a channel; remote 2 straddles two registers
    function automatic logic [2:0] cy_code(input logic [7:0] c1, input logic [7:0] c2, input int ch);
        logic [2:0] r;
        r = 3'h0;
        unique case (ch)
            0: r = c2[dfs_pkg::CTRL2_CY1_LSB +: 3];
            1: r = c2[dfs_pkg::CTRL2_CYL_LSB +: 3];
            default: r = {c1[dfs_pkg::CTRL1_CY2_HI_BIT], c2[dfs_pkg::CTRL2_CY2_LSB +: 2]};
        endcase
        return r;
    endfunction

    // signed compare of two 10-bit quarter values
    function automatic logic lt_q(input logic [9:0] a, input logic [9:0] b);
        return $signed(a) < $signed(b);
    endfunction

    // 8-bit register value to signed quarters, respecting number format
    function automatic logic [9:0] to_q(input logic [7:0] v, input logic ofs64);
        logic [7:0] s;
        s = ofs64 ? v - 8'h40 : v;
        return {s, 2'b00};
    endfunction

    // acoustic ramp step from 3-bit code
    function automatic logic [DUTY_W-1:0] ramp_step(input logic [2:0] c);
        logic [7:0] s;
        unique case (c)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0c;
            3'h6: s = 8'h18;
            3'h7: s = 8'h30;
        endcase
        return DUTY_W'(s);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        req;
        logic        wr;
        logic [7:0]  idx;
        logic        ofs;
        logic        alarm_edge;
        logic [10:0] per;
        logic        short_ev;
        logic        long_ev;
        logic [9:0]  t;
        logic [9:0]  opq;
        logic [9:0]  fq;
        logic [9:0]  rise;
        logic [11:0] nf;
        logic [11:0] floor_s;
        logic [11:0] hi_s;
        logic [DUTY_W-1:0] stp;
        logic [DUTY_W:0]   up;
        st_nxt   = st_r;
        req      = wb_cyc_i && wb_stb_i && !st_r.ack;
        wr       = req && wb_we_i && wb_sel_i[0];
        idx      = wb_adr_i[9:2];
        ofs      = st_r.mode[dfs_pkg::MODE_OFS64_BIT];
        t        = 10'h000;
        opq      = 10'h000;
        fq       = 10'h000;
        rise     = 10'h000;
        nf       = 12'h000;
        per      = 11'h000;
        short_ev = 1'b0;
        long_ev  = 1'b0;
        floor_s  = 12'h000;
        hi_s     = 12'h000;

        // alarm synchroniser; edge taken only past the first stage
        st_nxt.alarm_s1 = !thermal_alarm_n_i;                  // R22
        st_nxt.alarm_s2 = st_r.alarm_s1;
        st_nxt.alarm_s3 = st_r.alarm_s2;
        alarm_edge      = st_r.alarm_s2 && !st_r.alarm_s3;     // R22

        for (int ch = 0; ch < dfs_pkg::NCH; ch++) begin
            t   = ch_i[ch].temp;
            opq = to_q(st_r.op[ch], ofs);
            fq  = to_q(st_r.fst[ch], ofs);
            per = 11'(dfs_pkg::BASE_SHORT) << cy_code(st_r.ctrl1, st_r.ctrl2, ch); // R20
            if (mon_tick_i) begin
                // free-running per-channel counter over 2n cycles
                if (st_r.cnt[ch] >= 11'((2 * per) - 1)) begin
                    st_nxt.cnt[ch] = 11'h000;
                end else begin
                    st_nxt.cnt[ch] = st_r.cnt[ch] + 11'h001;
                end
                short_ev = (st_r.cnt[ch] == per - 11'h001) || (st_r.cnt[ch] == 11'((2 * per) - 1)); // R19 R23
                long_ev  = (st_r.cnt[ch] == 11'((2 * per) - 1));                                     // R19
                st_nxt.prev_temp[ch] = t;
                rise    = t - st_r.prev_temp[ch];
                nf      = {{4{st_r.fst[ch][7] & !ofs}}, st_r.fst[ch]};
                floor_s = ofs ? {4'h0, dfs_pkg::FLOOR_OFS64} : {4'hf, dfs_pkg::FLOOR_TWOS};
                hi_s    = ofs ? {4'h0, ch_i[ch].high_lim} : {{4{ch_i[ch].high_lim[7]}}, ch_i[ch].high_lim};
                // adjust only when enabled and not below fan start
                if (st_r.ctrl1[dfs_pkg::CTRL1_DYN_LSB + ch] && !lt_q(t, fq)) begin  // R16 R17 R11
                    // short: rise above op-hyst and faster than a quarter degree
                    if (short_ev && lt_q(opq - {ch_i[ch].hyst, 2'b00}, t)                // R01
                        && lt_q(dfs_pkg::SLOW_RISE_QTR, rise)) begin                     // R02 R03 R06
                        nf = nf - {3'h0, rise[9:2], 1'b0};                               // R02
                    end
                    // long: one degree down while above op
                    if (long_ev && lt_q(opq, t)) begin                                   // R04 R05
                        nf = nf - 12'h001;                                               // R05
                    end
                    // long: raise when cool, below limits and op
                    if (long_ev && lt_q(t, to_q(ch_i[ch].low_lim, ofs))                  // R07 R09
                        && lt_q(fq, to_q(ch_i[ch].high_lim, ofs))
                        && lt_q(fq, opq) && lt_q(fq, t)) begin
                        nf = nf + 12'h001;                                               // R07
                    end
                    if ($signed(nf) < $signed(floor_s)) begin
                        nf = floor_s;                                                    // R10
                    end
                    if ($signed(nf) > $signed(hi_s) && !(long_ev && lt_q(opq, t))) begin
                        nf = (nf > {4'h0, st_r.fst[ch]}) ? hi_s : nf;                    // R08
                    end
                    st_nxt.fst[ch] = nf[7:0];
                end
            end
            // capture current temperature into operating point
            if (alarm_edge && st_r.ctrl1[dfs_pkg::CTRL1_CAP_LSB + ch]) begin            // R12 R13 R14 R15
                st_nxt.op[ch] = t[9:2];                                                  // R21
            end
        end

        // acoustic smoothing of duty per update tick
        stp = ramp_step(st_r.acou[2:0]);
        up  = {1'b0, st_r.duty} + {1'b0, stp};
        if (!st_r.mode[dfs_pkg::MODE_ACOU_EN_BIT]) begin
            st_nxt.duty = duty_target_i;
        end else if (mon_tick_i) begin
            if (duty_target_i > st_r.duty) begin                                        // R18
                st_nxt.duty = (up[DUTY_W] || up[DUTY_W-1:0] > duty_target_i) ? duty_target_i : up[DUTY_W-1:0];
            end else if (duty_target_i < st_r.duty) begin
                st_nxt.duty = (st_r.duty - duty_target_i < stp) ? duty_target_i : st_r.duty - stp; // R18
            end
        end

        // wishbone: one-cycle ack, software write beats hardware update
        st_nxt.ack  = req;
        st_nxt.rdat = 32'h0000_0000;
        if (req) begin
            unique case (idx)
                dfs_pkg::IDX_OP_R1:   st_nxt.rdat = {24'h0, st_r.op[0]};
                dfs_pkg::IDX_OP_LOC:  st_nxt.rdat = {24'h0, st_r.op[1]};
                dfs_pkg::IDX_OP_R2:   st_nxt.rdat = {24'h0, st_r.op[2]};
                dfs_pkg::IDX_CTRL1:   st_nxt.rdat = {24'h0, st_r.ctrl1};
                dfs_pkg::IDX_CTRL2:   st_nxt.rdat = {24'h0, st_r.ctrl2};
                dfs_pkg::IDX_FST_R1:  st_nxt.rdat = {24'h0, st_r.fst[0]};
                dfs_pkg::IDX_FST_LOC: st_nxt.rdat = {24'h0, st_r.fst[1]};
                dfs_pkg::IDX_FST_R2:  st_nxt.rdat = {24'h0, st_r.fst[2]};
                dfs_pkg::IDX_MODE:    st_nxt.rdat = {24'h0, st_r.mode};
                dfs_pkg::IDX_ACOU:    st_nxt.rdat = {24'h0, st_r.acou};
                default:              st_nxt.rdat = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (idx)
                dfs_pkg::IDX_OP_R1:   st_nxt.op[0]  = wb_dat_i[7:0];
                dfs_pkg::IDX_OP_LOC:  st_nxt.op[1]  = wb_dat_i[7:0];
                dfs_pkg::IDX_OP_R2:   st_nxt.op[2]  = wb_dat_i[7:0];
                dfs_pkg::IDX_CTRL1:   st_nxt.ctrl1  = wb_dat_i[7:0];
                dfs_pkg::IDX_CTRL2:   st_nxt.ctrl2  = wb_dat_i[7:0];
                dfs_pkg::IDX_FST_R1:  st_nxt.fst[0] = wb_dat_i[7:0];
                dfs_pkg::IDX_FST_LOC: st_nxt.fst[1] = wb_dat_i[7:0];
                dfs_pkg::IDX_FST_R2:  st_nxt.fst[2] = wb_dat_i[7:0];
                dfs_pkg::IDX_MODE:    st_nxt.mode   = wb_dat_i[7:0];
                dfs_pkg::IDX_ACOU:    st_nxt.acou   = wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r           <= '0;
            st_r.op        <= {3{dfs_pkg::OP_RESET}};
            st_r.fst       <= {3{dfs_pkg::FST_RESET}};
            st_r.ctrl1     <= dfs_pkg::CTRL_RESET;
            st_r.ctrl2     <= dfs_pkg::CTRL_RESET;
            st_r.acou      <= dfs_pkg::ACOU_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o         = st_r.ack;
    assign wb_dat_o         = st_r.rdat;
    assign duty_o           = st_r.duty;
    assign fan_start_temp_o = {st_r.fst[2], st_r.fst[1], st_r.fst[0]};

    // fan held off while a channel sits below its start temperature
    for (genvar g = 0; g < dfs_pkg::NCH; g++) begin : g_off
        assign fan_off_o[g] = lt_q(ch_i[g].temp, to_q(st_r.fst[g], st_r.mode[dfs_pkg::MODE_OFS64_BIT])); // R11
    end

endmodule

//--- tb/dfs_cpu_hot_model.sv
// processor hot output model driving the active-low thermal alarm line
`timescale 1ns/1ns
module dfs_cpu_hot_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hot_req_i,
    output logic      thermal_alarm_n_o
);
    logic [2:0] low_cnt_r;
    // pull low for four cycles per request; released line sits at its pull-up level
    always_ff @(posedge clk_i) begin
        if (rst_i) low_cnt_r <= 3'h0;
        else if (hot_req_i) low_cnt_r <= 3'h4;
        else if (low_cnt_r != 3'h0) low_cnt_r <= low_cnt_r - 3'h1;
    end
    assign thermal_alarm_n_o = (low_cnt_r == 3'h0);
endmodule

//--- tb/dfs_loop_properties.sv
// port-level assertions for the fan-start loop
`timescale 1ns/1ns
module dfs_loop_properties #(
    parameter int DUTY_W = 8
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [9:0]            wb_adr_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  mon_tick_i,
    input wire dfs_pkg::dfs_chan_in_t ch_i [3],
    input wire logic                  thermal_alarm_n_i,
    input wire logic [DUTY_W-1:0]     duty_target_i,
    input wire logic [DUTY_W-1:0]     duty_o,
    input wire logic [23:0]           fan_start_temp_o,
    input wire logic [2:0]            fan_off_o
);
    logic [2:0] dyn_r;
    logic       ofs_r;
    wire logic  wr_c = wb_cyc_i & wb_stb_i & wb_we_i;
    // shadow of enables and format; signed checks only hold in twos format
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dyn_r <= 3'h0;
            ofs_r <= 1'b0;
        end else if (wr_c && wb_ack_o && wb_sel_i[0]) begin
            if (wb_adr_i[9:2] == dfs_pkg::IDX_CTRL1) dyn_r <= wb_dat_i[7:5];
            if (wb_adr_i[9:2] == dfs_pkg::IDX_MODE) ofs_r <= wb_dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_rd_zero; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
    property p_quiet; !mon_tick_i && !wr_c |=> $stable(fan_start_temp_o); endproperty
    property p_dyn_off; mon_tick_i && !dyn_r[0] && !wr_c |=> $stable(fan_start_temp_o[7:0]); endproperty
    property p_suspend; mon_tick_i && fan_off_o[0] && !wr_c |=> $stable(fan_start_temp_o[7:0]); endproperty
    property p_high;
        mon_tick_i && !wr_c && !ofs_r ##1 $signed(fan_start_temp_o[7:0]) > $signed($past(fan_start_temp_o[7:0]))
        |-> $signed(fan_start_temp_o[7:0]) <= $signed($past(ch_i[0].high_lim));
    endproperty
    property p_floor;
        mon_tick_i && !wr_c && !ofs_r ##1 !$stable(fan_start_temp_o[7:0]) |-> fan_start_temp_o[7:0] != 8'h80;
    endproperty
    property p_no_raise;
        mon_tick_i && !wr_c && !ofs_r && $signed(ch_i[0].temp) >= $signed({ch_i[0].low_lim, 2'b00})
        |=> $signed(fan_start_temp_o[7:0]) <= $signed($past(fan_start_temp_o[7:0]));
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_rd_zero: assert property (p_rd_zero) else $error("read data upper bits set");
    a_quiet: assert property (p_quiet) else $error("fan start moved without tick");
    a_dyn_off: assert property (p_dyn_off) else $error("disabled channel adjusted");
    a_suspend: assert property (p_suspend) else $error("adjusted while fan off");
    a_high: assert property (p_high) else $error("raised above high limit");
    a_floor: assert property (p_floor) else $error("fan start below floor");
    a_no_raise: assert property (p_no_raise) else $error("raised above low limit");
    c_dec: cover property (mon_tick_i ##1 fan_start_temp_o[7:0] < $past(fan_start_temp_o[7:0]));
    c_inc: cover property (mon_tick_i ##1 fan_start_temp_o[7:0] > $past(fan_start_temp_o[7:0]));
    c_alarm: cover property ($fell(thermal_alarm_n_i));
endmodule
bind dfs_loop dfs_loop_properties #(.DUTY_W(DUTY_W)) u_dfs_loop_properties (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mon_tick_i(mon_tick_i), .ch_i(ch_i), .thermal_alarm_n_i(thermal_alarm_n_i),
    .duty_target_i(duty_target_i), .duty_o(duty_o), .fan_start_temp_o(fan_start_temp_o), .fan_off_o(fan_off_o));

//--- tb/dfs_loop_bench.sv
// self-checking bench for the fan-start loop
`timescale 1ns/1ns
module dfs_loop_bench;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tick = 0, hot_req = 0;
    logic [9:0] adr = 10'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [7:0] d;
    logic [7:0] dtgt = 8'h40;
    dfs_pkg::dfs_chan_in_t ch [3];
    wire logic [31:0] rdat;
    wire logic [7:0] duty;
    wire logic [23:0] fst;
    wire logic [2:0] foff;
    wire logic ack, alarm_n;
    int errors = 0, comparisons = 0;
    always #2 clk_i = ~clk_i;
    dfs_loop u_dfs_loop (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .mon_tick_i(tick),
        .ch_i(ch), .thermal_alarm_n_i(alarm_n), .duty_target_i(dtgt), .duty_o(duty),
        .fan_start_temp_o(fst), .fan_off_o(foff));
    dfs_cpu_hot_model u_dfs_cpu_hot_model (.clk_i(clk_i), .rst_i(rst_i), .hot_req_i(hot_req),
        .thermal_alarm_n_o(alarm_n));
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // classic cycle: hold everything until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int t;
        t = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'h1};
        adr <= {idx, 2'b00};
        wdat <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        rd = rdat[7:0];
        if (t >= 50) errors++;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, d);
        chk(d, exp, "register read");
    endtask
    task automatic alarm();
        @(posedge clk_i) hot_req <= 1'b1;
        @(posedge clk_i) hot_req <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    // optional fan start write, then n ticks with remote-1 temp ramping by step quarters
    task automatic seg(input logic [7:0] fw, input logic [7:0] hi, input logic [9:0] t0, input logic [9:0] st,
                       input int n, input logic [7:0] exp);
        if (fw !== 8'hff) wb(1'b1, dfs_pkg::IDX_FST_R1, fw, d);
        @(posedge clk_i);
        ch[0].high_lim <= hi;
        ch[0].temp <= t0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i) tick <= 1'b1;
            @(posedge clk_i) tick <= 1'b0;
            ch[0].temp <= ch[0].temp + st;
        end
        @(posedge clk_i);
        chk(fst[7:0], exp, "fan start");
    endtask
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        ch[0] = '{10'd200, 8'h04, 8'h14, 8'h30};
        ch[1] = '{10'd240, 8'h04, 8'h01, 8'h7f};
        ch[2] = '{10'd280, 8'h04, 8'h01, 8'h7f};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) rd_chk(dfs_pkg::IDX_OP_R1 + 8'(i), 8'ha4);
        rd_chk(dfs_pkg::IDX_CTRL1, 8'h00);
        wb(1'b1, 8'h20, 8'h5c, d);
        rd_chk(8'h20, 8'h00);
        chk(fst[15:8], 8'h5a, "local fan start");
        $display("test reset done");
        wb(1'b1, dfs_pkg::IDX_OP_LOC, 8'h28, d);
        wb(1'b1, dfs_pkg::IDX_CTRL1, 8'h04, d);
        alarm();
        rd_chk(dfs_pkg::IDX_OP_R1, 8'h32);
        rd_chk(dfs_pkg::IDX_OP_LOC, 8'h28);
        wb(1'b1, dfs_pkg::IDX_CTRL1, 8'h18, d);
        ch[0].temp <= 10'd220;
        alarm();
        rd_chk(dfs_pkg::IDX_OP_LOC, 8'h3c);
        rd_chk(dfs_pkg::IDX_OP_R2, 8'h46);
        rd_chk(dfs_pkg::IDX_OP_R1, 8'h32);
        $display("test capture done");
        wb(1'b1, dfs_pkg::IDX_OP_R1, 8'h28, d);
        wb(1'b1, dfs_pkg::IDX_CTRL1, 8'h00, d);
        seg(8'h1e, 8'h30, 10'd200, 10'd0, 32, 8'h1e);
        wb(1'b1, dfs_pkg::IDX_CTRL1, 8'h20, d);
        rd_chk(dfs_pkg::IDX_CTRL1, 8'h20);
        seg(8'hff, 8'h30, 10'd200, 10'd0, 32, 8'h1c);
        seg(8'hff, 8'h30, 10'd204, 10'd4, 16, 8'h17);
        seg(8'hff, 8'h30, 10'd180, 10'd1, 16, 8'h16);
        seg(8'hff, 8'h30, 10'd152, 10'd0, 32, 8'h16);
        seg(8'hff, 8'h30, 10'd100, 10'd4, 8, 8'h16);
        seg(8'h0a, 8'h30, 10'd72, 10'd0, 32, 8'h0c);
        seg(8'h0c, 8'h0d, 10'd72, 10'd0, 64, 8'h0d);
        seg(8'h0c, 8'h30, 10'd100, 10'd0, 32, 8'h0c);
        seg(8'h0c, 8'h30, 10'd20, 10'd0, 32, 8'h0c);
        chk({7'h0, foff[0]}, 8'h01, "fan off");
        seg(8'h82, 8'h30, 10'd200, 10'd0, 32, 8'h81);
        wb(1'b1, dfs_pkg::IDX_CTRL2, 8'h01, d);
        seg(8'h1e, 8'h30, 10'd200, 10'd0, 32, 8'h1d);
        chk(fst[23:16], 8'h5a, "remote2 fan start");
        chk(duty, 8'h40, "duty follow");
        // acoustic mode: step code 4 moves duty by 8 per tick toward target
        wb(1'b1, dfs_pkg::IDX_ACOU, 8'h04, d);
        wb(1'b1, dfs_pkg::IDX_MODE, 8'h02, d);
        dtgt <= 8'h60;
        @(posedge clk_i) tick <= 1'b1;
        @(posedge clk_i) tick <= 1'b0;
        @(posedge clk_i);
        chk(duty, 8'h48, "duty ramp");
        $display("test loop done");
        stop_test();
    end
    // watchdog well beyond the roughly 900 cycles the tests need
    initial begin
        #200000;
        errors++;
        stop_test();
    end
endmodule
